// ---- src/dsom_consts.svh ----
/*
 Constants of the drive status output mapper: register offsets, reset
 values, selection codes, field positions and synchroniser layout.
 Assumes inclusion by bare name from the design file.
*/
`ifndef DSOM_CONSTS_SVH
`define DSOM_CONSTS_SVH

// Register byte offsets on the bus
`define DSOM_ADR_SEL0 8'h00
`define DSOM_ADR_SEL1 8'h04
`define DSOM_ADR_SEL2 8'h08
`define DSOM_ADR_SEL3 8'h0c
`define DSOM_ADR_SEL4 8'h10
`define DSOM_ADR_SEL5 8'h14
`define DSOM_ADR_LEVEL 8'h18
`define DSOM_ADR_STATION 8'h1c
`define DSOM_ADR_STATUS 8'h20
`define DSOM_ADR_IRQ_STAT 8'h24
`define DSOM_ADR_IRQ_MASK 8'h28

// Output function codes, positive and negative polarity
`define DSOM_CODE_RUN_POS 8'h00
`define DSOM_CODE_READY_POS 8'h0b
`define DSOM_CODE_CUR_POS 8'h0c
`define DSOM_CODE_FAULT_POS 8'h63
`define DSOM_CODE_RUN_NEG 8'h64
`define DSOM_CODE_READY_NEG 8'h6f
`define DSOM_CODE_CUR_NEG 8'h70
`define DSOM_CODE_FAULT_NEG 8'hc7

// Reset values of the selection registers
`define DSOM_RST_SEL0 8'h00
`define DSOM_RST_SEL1 8'h63
`define DSOM_RST_SEL2 8'h0b
`define DSOM_RST_SEL3 8'h00
`define DSOM_RST_SEL4 8'h0c
`define DSOM_RST_SEL5 8'h63

// Current detect level in percent of rated current
`define DSOM_RST_LEVEL 8'h96

// Station register fields
`define DSOM_STN_VER2 0
`define DSOM_STN_MULT_LO 1
`define DSOM_STN_MULT_HI 2
`define DSOM_STN_OCC_LO 4
`define DSOM_STN_OCC_HI 7
`define DSOM_STN_OCCUPIED 4'h1
`define DSOM_MULT_SINGLE 2'h0

// Synchronised input positions
`define DSOM_IN_TRIP 0
`define DSOM_IN_OPER 1
`define DSOM_IN_RUN 2
`define DSOM_IN_MOTOR 3
`define DSOM_IN_FWD 4
`define DSOM_IN_REV 5
`define DSOM_IN_W 6

// Status register fields above the indications
`define DSOM_ST_FWD 4
`define DSOM_ST_REV 5
`define DSOM_ST_NORUN 6
`define DSOM_ST_TRIP 7

`define DSOM_NTERM 6

`endif

// ---- src/dsom_pkg.sv ----
/*
 Types of the drive status output mapper.
 Assumes nothing of its surroundings.
*/
package dsom_pkg;

   typedef struct packed {
      logic current_detected_indication;
      logic running_indication;
      logic operation_ready_indication;
      logic fault_indication;
   } dsom_ind_type;

endpackage

// ---- src/dsom_top.sv ----
/*
 Drive status output mapper: status indications of a motor drive routed
 with selectable polarity to three physical and three virtual terminals,
 registers on a classic Wishbone slave, sticky event interrupt.
 Assumes drive status pins asynchronous to mclk and a current sample in
 percent of rated current produced on mclk.
*/
// Behaviour
// R1: Protective trip asserts the fault indication
// R2: Negative fault polarity: active healthy, inactive faulted
// R3: Ready only once powered and operative
// R4: Running held through deceleration until output stops
// R5: Running routed to first terminal after reset
// R6: Current detected above level, initially 150%
// R7: Current detected held until output stops
// R8: Positive codes 99, 11, 0, 12
// R9: Negative codes plus 100; six selections
// R10: Controller checks running follows start commands
// R11: One station; version two multiplies registers
// R12: Selection change acts at next edge
`timescale 1ns/10ps
`include "dsom_consts.svh"

module dsom_top
   import dsom_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic protective_trip,
   input wire logic drive_operative,
   input wire logic drive_running,
   input wire logic motor_output_active,
   input wire logic forward_start_cmd,
   input wire logic reverse_start_cmd,
   input wire logic [9:0] motor_current_pct,
   output logic first_output_terminal,
   output logic output_terminal_2,
   output logic output_terminal_3,
   output logic [2:0] virtual_terminal,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////
   // Input synchronisers: three stages, change taken when 2nd and 3rd agree
   logic [`DSOM_IN_W-1:0] pin_in;
   logic [`DSOM_IN_W-1:0] sy1_ff, sy2_ff, sy3_ff, flt_ff;
   logic [`DSOM_IN_W-1:0] nxt_sy1, nxt_sy2, nxt_sy3, nxt_flt;

   assign pin_in = {reverse_start_cmd, forward_start_cmd, motor_output_active,
                    drive_running, drive_operative, protective_trip};

   always_comb begin
      nxt_sy1 = pin_in;
      nxt_sy2 = sy1_ff;
      nxt_sy3 = sy2_ff;
      nxt_flt = (sy2_ff & ~(sy2_ff ^ sy3_ff)) | (flt_ff & (sy2_ff ^ sy3_ff));
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sy1_ff <= '0;
         sy2_ff <= '0;
         sy3_ff <= '0;
         flt_ff <= '0;
      end else begin
         sy1_ff <= nxt_sy1;
         sy2_ff <= nxt_sy2;
         sy3_ff <= nxt_sy3;
         flt_ff <= nxt_flt;
      end
   end

   logic trip_f, oper_f, run_f, motor_f, fwd_f, rev_f;
   assign trip_f = flt_ff[`DSOM_IN_TRIP];
   assign oper_f = flt_ff[`DSOM_IN_OPER];
   assign run_f = flt_ff[`DSOM_IN_RUN];
   assign motor_f = flt_ff[`DSOM_IN_MOTOR];
   assign fwd_f = flt_ff[`DSOM_IN_FWD];
   assign rev_f = flt_ff[`DSOM_IN_REV];

   ////////////////////////////////////////////////////////////////////
   // Bus slave and registers
   logic [`DSOM_NTERM-1:0][7:0] sel_ff, nxt_sel;
   logic [7:0] current_detect_level_setting_ff, nxt_level;
   logic [2:0] stn_ff, nxt_stn;
   logic [3:0] istat_ff, nxt_istat, imask_ff, nxt_imask;
   logic ack_ff, nxt_ack;
   logic [31:0] dat_ff, nxt_dat;
   logic wr_en;
   logic [31:0] rdata;
   logic [3:0] ev;
   logic [1:0] eff_mult;
   logic [7:0] status_byte;
   dsom_ind_type ind_ff;

   assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff & wb_sel_i[0];
   // Multiplied register settings only exist under version two
   assign eff_mult = stn_ff[0] ? stn_ff[2:1] : `DSOM_MULT_SINGLE; // see R11
   assign status_byte = {trip_f, (fwd_f | rev_f) & ~ind_ff.running_indication,
                         rev_f, fwd_f, ind_ff};

   always_comb begin
      rdata = '0;
      unique case (wb_adr_i)
         `DSOM_ADR_SEL0: rdata[7:0] = sel_ff[0];
         `DSOM_ADR_SEL1: rdata[7:0] = sel_ff[1];
         `DSOM_ADR_SEL2: rdata[7:0] = sel_ff[2];
         `DSOM_ADR_SEL3: rdata[7:0] = sel_ff[3];
         `DSOM_ADR_SEL4: rdata[7:0] = sel_ff[4];
         `DSOM_ADR_SEL5: rdata[7:0] = sel_ff[5];
         `DSOM_ADR_LEVEL: rdata[7:0] = current_detect_level_setting_ff;
         `DSOM_ADR_STATION: begin
            rdata[`DSOM_STN_VER2] = stn_ff[0];
            rdata[`DSOM_STN_MULT_HI:`DSOM_STN_MULT_LO] = eff_mult;
            rdata[`DSOM_STN_OCC_HI:`DSOM_STN_OCC_LO] = `DSOM_STN_OCCUPIED; // see R11
         end
         `DSOM_ADR_STATUS: rdata[7:0] = status_byte;
         `DSOM_ADR_IRQ_STAT: rdata[3:0] = istat_ff;
         `DSOM_ADR_IRQ_MASK: rdata[3:0] = imask_ff;
         default: rdata = '0;
      endcase
   end

   always_comb begin
      nxt_ack = wb_cyc_i & wb_stb_i & ~ack_ff;
      nxt_dat = nxt_ack ? rdata : '0;
      nxt_sel = sel_ff;
      nxt_level = current_detect_level_setting_ff;
      nxt_stn = stn_ff;
      nxt_imask = imask_ff;
      nxt_istat = istat_ff;
      if (wr_en) begin
         unique case (wb_adr_i)
            `DSOM_ADR_SEL0: nxt_sel[0] = wb_dat_i[7:0]; // see R12
            `DSOM_ADR_SEL1: nxt_sel[1] = wb_dat_i[7:0];
            `DSOM_ADR_SEL2: nxt_sel[2] = wb_dat_i[7:0];
            `DSOM_ADR_SEL3: nxt_sel[3] = wb_dat_i[7:0];
            `DSOM_ADR_SEL4: nxt_sel[4] = wb_dat_i[7:0];
            `DSOM_ADR_SEL5: nxt_sel[5] = wb_dat_i[7:0];
            `DSOM_ADR_LEVEL: nxt_level = wb_dat_i[7:0];
            `DSOM_ADR_STATION: nxt_stn = wb_dat_i[2:0];
            `DSOM_ADR_IRQ_STAT: nxt_istat = istat_ff & ~wb_dat_i[3:0];
            `DSOM_ADR_IRQ_MASK: nxt_imask = wb_dat_i[3:0];
            default: nxt_stn = stn_ff;
         endcase
      end
      // A new event wins over a clear in the same cycle
      nxt_istat = nxt_istat | ev;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ack_ff <= 1'b0;
         dat_ff <= '0;
         sel_ff[0] <= `DSOM_RST_SEL0; // see R5
         sel_ff[1] <= `DSOM_RST_SEL1;
         sel_ff[2] <= `DSOM_RST_SEL2;
         sel_ff[3] <= `DSOM_RST_SEL3;
         sel_ff[4] <= `DSOM_RST_SEL4;
         sel_ff[5] <= `DSOM_RST_SEL5;
         current_detect_level_setting_ff <= `DSOM_RST_LEVEL; // see R6
         stn_ff <= '0;
         istat_ff <= '0;
         imask_ff <= '0;
      end else begin
         ack_ff <= nxt_ack;
         dat_ff <= nxt_dat;
         sel_ff <= nxt_sel;
         current_detect_level_setting_ff <= nxt_level;
         stn_ff <= nxt_stn;
         istat_ff <= nxt_istat;
         imask_ff <= nxt_imask;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;

   ////////////////////////////////////////////////////////////////////
   // Indications
   dsom_ind_type nxt_ind;

   always_comb begin
      nxt_ind.fault_indication = trip_f; // see R1
      nxt_ind.operation_ready_indication = oper_f; // see R3
      // Output to the motor keeps both alive through deceleration
      nxt_ind.running_indication = run_f | motor_f; // see R4
      nxt_ind.current_detected_indication =
         (motor_current_pct > {2'b00, current_detect_level_setting_ff}) | // see R6
         (ind_ff.current_detected_indication & motor_f); // see R7
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ind_ff <= '0;
      end else begin
         ind_ff <= nxt_ind;
      end
   end

   assign ev = nxt_ind & ~ind_ff;

   ////////////////////////////////////////////////////////////////////
   // Terminal mapping and interrupt
   function automatic logic map_code(input logic [7:0] code, input dsom_ind_type i);
      case (code) // see R8 see R9
         `DSOM_CODE_FAULT_POS: map_code = i.fault_indication;
         `DSOM_CODE_FAULT_NEG: map_code = ~i.fault_indication; // see R2
         `DSOM_CODE_READY_POS: map_code = i.operation_ready_indication;
         `DSOM_CODE_READY_NEG: map_code = ~i.operation_ready_indication;
         `DSOM_CODE_RUN_POS: map_code = i.running_indication;
         `DSOM_CODE_RUN_NEG: map_code = ~i.running_indication;
         `DSOM_CODE_CUR_POS: map_code = i.current_detected_indication;
         `DSOM_CODE_CUR_NEG: map_code = ~i.current_detected_indication;
         default: map_code = 1'b0;
      endcase
   endfunction

   logic [`DSOM_NTERM-1:0] term_ff, nxt_term;
   logic irq_ff, nxt_irq;

   always_comb begin
      for (int t = 0; t < `DSOM_NTERM; t++) begin
         nxt_term[t] = map_code(sel_ff[t], ind_ff); // see R12
      end
      nxt_irq = |(nxt_istat & nxt_imask);
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         term_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         term_ff <= nxt_term;
         irq_ff <= nxt_irq;
      end
   end

   assign first_output_terminal = term_ff[0];
   assign output_terminal_2 = term_ff[1];
   assign output_terminal_3 = term_ff[2];
   assign virtual_terminal = term_ff[5:3];
   assign irq = irq_ff;

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   logic sel0_written_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sel0_written_ff <= 1'b0;
      end else if (wr_en && wb_adr_i == `DSOM_ADR_SEL0) begin
         sel0_written_ff <= 1'b1;
      end
   end

   chk_fault_on_trip: assert property (trip_f |=> ind_ff.fault_indication) // see R1
      else $error("fault indication missing after trip");
   chk_fault_neg_pol: assert property ((sel_ff[1] == `DSOM_CODE_FAULT_NEG) ##1 // see R2
         (sel_ff[1] == `DSOM_CODE_FAULT_NEG) |-> output_terminal_2 == !$past(ind_ff.fault_indication))
      else $error("negative fault polarity wrong");
   chk_ready_gate: assert property (!oper_f |=> !ind_ff.operation_ready_indication) // see R3
      else $error("ready asserted before operative");
   chk_run_decel: assert property (motor_f |=> ind_ff.running_indication [*1] ##1 // see R4
         (first_output_terminal || sel_ff[0] != `DSOM_CODE_RUN_POS || !$past(motor_f, 2)
          || $past(sel_ff[0]) != `DSOM_CODE_RUN_POS))
      else $error("running dropped while output active");
   chk_default_route: assert property (!sel0_written_ff |-> sel_ff[0] == `DSOM_RST_SEL0) // see R5
      else $error("first terminal not routed to running");
   chk_cur_level: assert property ( // see R6
         (motor_current_pct > {2'b00, current_detect_level_setting_ff})
         |=> ind_ff.current_detected_indication)
      else $error("current detect missed");
   chk_cur_hold: assert property ((ind_ff.current_detected_indication && motor_f) // see R7
         |=> ind_ff.current_detected_indication)
      else $error("current detect dropped early");
   chk_ready_code: assert property ((sel_ff[2] == `DSOM_CODE_READY_POS) // see R8
         |=> output_terminal_3 == $past(ind_ff.operation_ready_indication))
      else $error("ready code mapping wrong");
   chk_run_neg_code: assert property ((sel_ff[3] == `DSOM_CODE_RUN_NEG) // see R9
         |=> virtual_terminal[0] == !$past(ind_ff.running_indication))
      else $error("negative running mapping wrong");
   chk_single_mult: assert property (!stn_ff[0] |-> eff_mult == `DSOM_MULT_SINGLE) // see R11
      else $error("multiplied setting without version two");
   chk_sel_latency: assert property ((wr_en && wb_adr_i == `DSOM_ADR_SEL3) // see R12
         |=> sel_ff[3] == $past(wb_dat_i[7:0]) ##1
         virtual_terminal[0] == $past(map_code(sel_ff[3], ind_ff)))
      else $error("selection change latency wrong");
   chk_irq_level: assert property (|(istat_ff & imask_ff) |-> irq_ff)
      else $error("interrupt not raised");

   cov_trip_fault: cover property (trip_f ##2 output_terminal_2);
   cov_run_decel: cover property ((run_f && motor_f) ##1 (!run_f && motor_f) [*3] ##1 !motor_f);
   cov_cur_detect: cover property ($rose(ind_ff.current_detected_indication));
   cov_irq: cover property ($rose(irq_ff));

endmodule

// ---- bench/dsom_drive_model.sv ----
/*
 Drive side model: start commands from the controller, running and
 motor output levels with a deceleration tail after the command drops.
 Assumes the bench requests starts on mclk.
*/
`timescale 1ns/10ps

module dsom_drive_model #(
   parameter int DECEL = 40
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic run_fwd,
   input wire logic run_rev,
   output logic forward_start_cmd,
   output logic reverse_start_cmd,
   output logic drive_running,
   output logic motor_output_active
);
   logic [7:0] decel_ff;

   assign forward_start_cmd = run_fwd;
   assign reverse_start_cmd = run_rev;

   // Output stays on until the deceleration tail has run out
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         drive_running <= 1'b0;
         motor_output_active <= 1'b0;
         decel_ff <= 8'h00;
      end else begin
         drive_running <= run_fwd | run_rev;
         if (run_fwd | run_rev) begin
            decel_ff <= 8'(DECEL);
         end else if (decel_ff != 8'h00) begin
            decel_ff <= decel_ff - 8'h01;
         end
         motor_output_active <= run_fwd | run_rev | (decel_ff > 8'h01);
      end
   end
endmodule

// ---- bench/tb_top.sv ----
/*
 Self-checking bench of the drive status output mapper: Wishbone
 register accesses, drive status stimulus and terminal checks.
 Assumes the design files under src/ are compiled first.
*/
`timescale 1ns/10ps
`include "dsom_consts.svh"

module tb_top;
   import dsom_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic wb_ack_o, irq;
   logic protective_trip = 1'b0, drive_operative = 1'b0;
   logic run_fwd = 1'b0, run_rev = 1'b0;
   logic forward_start_cmd, reverse_start_cmd, drive_running, motor_output_active;
   logic [9:0] motor_current_pct = 10'h000;
   logic first_output_terminal, output_terminal_2, output_terminal_3;
   logic [2:0] virtual_terminal;
   logic [7:0] codes [9] = '{`DSOM_CODE_FAULT_POS, `DSOM_CODE_FAULT_NEG, `DSOM_CODE_READY_POS,
      `DSOM_CODE_READY_NEG, `DSOM_CODE_RUN_POS, `DSOM_CODE_RUN_NEG, `DSOM_CODE_CUR_POS,
      `DSOM_CODE_CUR_NEG, 8'h05};
   logic exp_vt [9] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   logic [7:0] rst_vals [8] = '{`DSOM_RST_SEL0, `DSOM_RST_SEL1, `DSOM_RST_SEL2, `DSOM_RST_SEL3,
      `DSOM_RST_SEL4, `DSOM_RST_SEL5, 8'h96, 8'h10};
   int n_mismatch = 0;
   int compares = 0;

   always #50 mclk = ~mclk;

   dsom_drive_model #(.DECEL(40)) drive (.mclk(mclk), .rst(rst), .run_fwd(run_fwd),
      .run_rev(run_rev), .forward_start_cmd(forward_start_cmd),
      .reverse_start_cmd(reverse_start_cmd), .drive_running(drive_running),
      .motor_output_active(motor_output_active));

   dsom_top DUT (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .protective_trip(protective_trip),
      .drive_operative(drive_operative), .drive_running(drive_running),
      .motor_output_active(motor_output_active), .forward_start_cmd(forward_start_cmd),
      .reverse_start_cmd(reverse_start_cmd), .motor_current_pct(motor_current_pct),
      .first_output_terminal(first_output_terminal), .output_terminal_2(output_terminal_2),
      .output_terminal_3(output_terminal_3), .virtual_terminal(virtual_terminal), .irq(irq));

   task automatic test_done();
      if (n_mismatch == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Classic single cycle; holds the request until ack is seen
   task automatic wb(logic we, logic [7:0] adr, logic [31:0] dat);
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= 4'hf;
      do @(posedge mclk); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask

   task automatic rchk(logic [7:0] adr, logic [31:0] exp);
      wb(1'b0, adr, 32'h0);
      chk("register read", exp, rd);
   endtask

   task automatic w(int n);
      repeat (n) @(negedge mclk);
   endtask

   initial begin
      #200_000;
      n_mismatch++;
      test_done();
   end

   initial begin
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) rchk(8'(4 * i), 32'(rst_vals[i]));
      rchk(`DSOM_ADR_IRQ_MASK, 32'h0);
      rchk(8'h2c, 32'h0);
      wb(1'b1, `DSOM_ADR_STATION, 32'h05);
      rchk(`DSOM_ADR_STATION, 32'h15);
      w(8);
      chk("ready before operative", 0, output_terminal_3);
      @(posedge mclk);
      drive_operative <= 1'b1;
      w(8);
      chk("ready once operative", 1, output_terminal_3);
      chk("fault healthy", 0, output_terminal_2);
      @(posedge mclk);
      protective_trip <= 1'b1;
      w(8);
      chk("fault on trip", 1, output_terminal_2);
      chk("fault on virtual", 1, virtual_terminal[2]);
      wb(1'b1, `DSOM_ADR_SEL1, 32'(`DSOM_CODE_FAULT_NEG));
      w(2);
      chk("negative fault tripped", 0, output_terminal_2);
      @(posedge mclk);
      protective_trip <= 1'b0;
      w(8);
      chk("negative fault healthy", 1, output_terminal_2);
      @(posedge mclk);
      run_fwd <= 1'b1;
      motor_current_pct <= 10'd150;
      w(10);
      chk("running on start", 1, first_output_terminal);
      chk("current at level", 0, virtual_terminal[1]);
      rchk(`DSOM_ADR_STATUS, 32'h16);
      @(posedge mclk);
      motor_current_pct <= 10'd151;
      w(4);
      chk("current above level", 1, virtual_terminal[1]);
      @(posedge mclk);
      motor_current_pct <= 10'd0;
      run_fwd <= 1'b0;
      w(20);
      chk("running in decel", 1, first_output_terminal);
      chk("current in decel", 1, virtual_terminal[1]);
      w(40);
      chk("running stopped", 0, first_output_terminal);
      chk("current stopped", 0, virtual_terminal[1]);
      @(posedge mclk);
      run_rev <= 1'b1;
      w(10);
      chk("running on reverse", 1, first_output_terminal);
      @(posedge mclk);
      run_rev <= 1'b0;
      w(60);
      for (int i = 0; i < 9; i++) begin
         wb(1'b1, `DSOM_ADR_SEL3, 32'(codes[i]));
         w(2);
         chk("mapped code", 32'(exp_vt[i]), 32'(virtual_terminal[0]));
      end
      rchk(`DSOM_ADR_IRQ_STAT, 32'h0f);
      chk("irq masked", 0, irq);
      wb(1'b1, `DSOM_ADR_IRQ_STAT, 32'h0f);
      rchk(`DSOM_ADR_IRQ_STAT, 32'h00);
      wb(1'b1, `DSOM_ADR_IRQ_MASK, 32'h01);
      @(posedge mclk);
      protective_trip <= 1'b1;
      w(8);
      chk("irq on fault", 1, irq);
      wb(1'b1, `DSOM_ADR_IRQ_STAT, 32'h01);
      w(2);
      chk("irq cleared", 0, irq);
      rchk(`DSOM_ADR_STATUS, 32'h83);
      test_done();
   end
endmodule
